/* File: rtl/pam_activity_monitor.sv */
// pam_activity_monitor: decode layer of fourteen peripheral activity monitors.
// assumes pci cycle strobes come from logic on clk; acks and gpis are pins.
`timescale 1ns/10ps
module pam_activity_monitor
    import pam_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic pci_cyc_valid,
    input wire logic pci_cyc_io,
    input wire logic pci_cyc_mem,
    input wire logic pci_cyc_write,
    input wire logic [31:0] pci_addr,
    input wire logic [7:0] pci_wdata,
    input wire logic pci_cyc_ext_ide,
    input wire logic primary_ide_dma_ack_n,
    input wire logic secondary_ide_dma_ack_n,
    input wire logic [7:0] isa_dma_ack_n,
    input wire logic [13:0] general_purpose_input,
    input wire logic irq_activity,
    input wire logic irq_global_reload_enable,
    input wire logic internal_ide_enable,
    input wire logic [1:0] bus_master_ide_active,
    input wire logic [13:0] range_enable,
    input wire logic [13:4] range_is_mem,
    input wire logic [13:4][31:0] range_base,
    input wire logic [13:4][31:0] range_mask,
    input wire logic [13:0] forward_enable,
    input wire logic [13:0] idle_reload_en,
    input wire logic [13:0] global_reload_en,
    input wire logic [13:0] burst_reload_en,
    input wire logic [13:0] burst_fast_sel,
    input wire logic [13:0] trap_enable,
    input wire logic [13:0] idle_smi_enable,
    input wire logic [13:0] gpi_enable,
    input wire logic [13:0] gpi_polarity,
    input wire logic [7:0] audio_dack_enable,
    input wire logic lpt_dack_enable,
    input wire logic [1:0] lpt_dma_channel,
    input wire logic software_reload_disable,
    input wire logic idle_timer_freeze,
    input wire logic idle_tick,
    input wire logic [3:0] idle_count_group_a,
    input wire logic [4:0] idle_count_group_b,
    input wire logic [7:0] idle_count_group_c,
    input wire logic [7:0] idle_count_group_d,
    input wire logic [3:0] software_timer_count,
    input wire logic [7:0] bus_master_idle_count,
    input wire logic [13:0] idle_status_clear,
    input wire logic [13:0] trap_status_clear,
    output logic global_reload,
    output logic fast_burst_reload,
    output logic slow_burst_reload,
    output logic [13:0] idle_reload,
    output logic isa_forward,
    output logic [1:0] drive_select_shadow,
    output logic [13:0] idle_status,
    output logic [13:0] trap_status,
    output logic system_mgmt_interrupt_n
);
    typedef struct packed {
        logic [1:0] drv;
        logic [13:0] idle_sts;
        logic [13:0] trap_sts;
        logic [13:0] idle_rld;
        logic glob;
        logic fast;
        logic slow;
        logic fwd;
        logic smi;
        logic irq_prev;
    } pam_state_t;

    pam_state_t st;
    pam_state_t next_st;

    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    logic [9:0] dack_now;
    logic [9:0] dack_was;
    logic [13:0] gpi_now;
    logic [13:0] gpi_was;

    pam_sync_edge #(.W(10)) u_dack_sync (
        .clk(clk),
        .rst_b(rst_b),
        .d(~{isa_dma_ack_n, secondary_ide_dma_ack_n, primary_ide_dma_ack_n}),
        .now(dack_now),
        .was(dack_was)
    );

    pam_sync_edge #(.W(14)) u_gpi_sync (
        .clk(clk),
        .rst_b(rst_b),
        .d(general_purpose_input),
        .now(gpi_now),
        .was(gpi_was)
    );

    logic [9:0] dack_rise;
    logic [13:0] gpi_rise;
    assign dack_rise = dack_now & ~dack_was;
    // assertion edge of the selected polarity only, so a held input pulses once
    assign gpi_rise = gpi_enable & PAM_HAS_GPI
        & ((gpi_polarity & gpi_now & ~gpi_was) | (~gpi_polarity & ~gpi_now & gpi_was));

    // ----------------------------------------
    // pci address decode
    // ----------------------------------------
    logic io_cyc;
    logic [15:0] ioa;
    logic pri_hit;
    logic sec_hit;
    logic isa_only;
    logic [13:0] match;
    logic [13:0] acc;
    logic [13:0] dack_ev;
    logic [13:0] act;
    logic [13:0] fwd_hit;
    logic [13:0] trap_set;
    logic [13:0] expire_v;
    logic irq_rise;
    logic [9:0] lpt_dack;

    assign ioa = pci_addr[15:0];
    assign io_cyc = pci_cyc_valid && pci_cyc_io && (pci_addr[31:16] == 16'h0000);
    assign pri_hit = io_cyc && (((ioa >= PAM_PRI_LO) && (ioa <= PAM_PRI_HI))
        || (ioa == PAM_PRI_ALT));
    assign sec_hit = io_cyc && (((ioa >= PAM_SEC_LO) && (ioa <= PAM_SEC_HI))
        || (ioa == PAM_SEC_ALT));
    // these peripherals are never on pci, so their cycles always go to isa
    assign isa_only = io_cyc && ((ioa == PAM_KBC_DATA) || (ioa == PAM_KBC_CMD)
        || ((ioa >= PAM_RTC_LO) && (ioa <= PAM_RTC_HI)));

    // drive select uses the shadow held before this cycle's own write
    assign match[0] = pri_hit && !st.drv[0];
    assign match[1] = pri_hit && st.drv[0];
    assign match[2] = sec_hit && !st.drv[1];
    assign match[3] = sec_hit && st.drv[1];

    genvar gi;
    generate
        for (gi = 4; gi < PAM_NUM_MON; gi++) begin : g_rng
            assign match[gi] = pci_cyc_valid
                && (range_is_mem[gi] ? pci_cyc_mem : pci_cyc_io)
                && (((pci_addr ^ range_base[gi]) & range_mask[gi]) == 32'h0000_0000);
        end
    endgenerate

    // external pci ide cycles are observed but never counted as activity
    assign acc = (pci_cyc_ext_ide ? 14'h0000 : (match & range_enable));
    assign fwd_hit = match & range_enable & forward_enable;

    assign lpt_dack = dack_rise >> (lpt_dma_channel[1] ? 4'd5 : {3'd0, lpt_dma_channel[0]} + 4'd2);
    assign dack_ev[0] = dack_rise[0] && !st.drv[0] && bus_master_ide_active[0];
    assign dack_ev[1] = dack_rise[0] && st.drv[0] && bus_master_ide_active[0];
    assign dack_ev[2] = dack_rise[1] && !st.drv[1] && bus_master_ide_active[1];
    assign dack_ev[3] = dack_rise[1] && st.drv[1] && bus_master_ide_active[1];
    assign dack_ev[4] = |(dack_rise[9:2] & audio_dack_enable);
    assign dack_ev[5] = dack_rise[PAM_DACK_FDD + 2];
    assign dack_ev[7:6] = 2'b00;
    assign dack_ev[8] = lpt_dack_enable && lpt_dack[0];
    assign dack_ev[13:9] = 5'h00;

    assign act = acc | dack_ev | gpi_rise;
    assign irq_rise = irq_activity && !st.irq_prev;
    // ide traps need the internal controller to claim the cycle
    assign trap_set = acc & trap_enable
        & ~(PAM_IDE_MON & {14{!internal_ide_enable}});

    // ----------------------------------------
    // idle timers, monitors 0 to 11
    // ----------------------------------------
    generate
        for (gi = 0; gi < PAM_NUM_TMR; gi++) begin : g_tmr
            pam_timer_if tif ();
            assign tif.enable = idle_reload_en[gi];
            assign tif.reload = st.idle_rld[gi];
            assign tif.tick = idle_tick;
            assign tif.freeze = idle_timer_freeze;
            if (gi < 3) begin : g_a
                assign tif.load_value = {4'h0, idle_count_group_a};
            end else if (gi == 3) begin : g_sw
                assign tif.load_value = {4'h0, software_timer_count};
            end else if (gi < 8) begin : g_b
                assign tif.load_value = {3'h0, idle_count_group_b};
            end else if (gi == 8) begin : g_bm
                assign tif.load_value = bus_master_idle_count;
            end else if (gi < 11) begin : g_c
                assign tif.load_value = idle_count_group_c;
            end else begin : g_d
                assign tif.load_value = idle_count_group_d;
            end
            assign expire_v[gi] = tif.expire;
            pam_idle_timer u_tmr (
                .clk(clk),
                .rst_b(rst_b),
                .t(tif.timer)
            );
        end
    endgenerate
    assign expire_v[13:12] = 2'b00;

    // ----------------------------------------
    // state update
    // ----------------------------------------
    always_comb begin
        next_st = st;
        next_st.irq_prev = irq_activity;
        if (io_cyc && pci_cyc_write && (ioa == PAM_PRI_DRVHD)) begin
            next_st.drv[0] = pci_wdata[PAM_DRV_BIT];
        end
        if (io_cyc && pci_cyc_write && (ioa == PAM_SEC_DRVHD)) begin
            next_st.drv[1] = pci_wdata[PAM_DRV_BIT];
        end
        // set beats clear so an event in the clearing cycle survives
        next_st.idle_sts = (st.idle_sts & ~idle_status_clear) | expire_v;
        next_st.trap_sts = (st.trap_sts & ~trap_status_clear) | trap_set;
        // the software timer can be told to ignore activity
        next_st.idle_rld = act & idle_reload_en & PAM_HAS_TIMER
            & ~{10'h000, software_reload_disable, 3'h0};
        next_st.glob = (|(act & global_reload_en))
            || (irq_rise && irq_global_reload_enable);
        next_st.fast = |(act & burst_reload_en & burst_fast_sel & PAM_FAST_OK);
        next_st.slow = |(act & burst_reload_en & ~burst_fast_sel & PAM_SLOW_OK);
        next_st.fwd = (|fwd_hit) || isa_only;
        next_st.smi = |((next_st.idle_sts & idle_smi_enable) | next_st.trap_sts);
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign global_reload = st.glob;
    assign fast_burst_reload = st.fast;
    assign slow_burst_reload = st.slow;
    assign idle_reload = st.idle_rld;
    assign isa_forward = st.fwd;
    assign drive_select_shadow = st.drv;
    assign idle_status = st.idle_sts;
    assign trap_status = st.trap_sts;
    assign system_mgmt_interrupt_n = !st.smi;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    a_kbc_rtc_forward: assert property (isa_only |=> isa_forward)
        else $error("keyboard or rtc cycle not forwarded to isa");
    a_pci_only_access: assert property (!pci_cyc_valid |-> acc == 14'h0000)
        else $error("access event without a pci cycle");
    a_forward_on_hit: assert property (fwd_hit != 14'h0000 |=> isa_forward)
        else $error("enabled forwarding hit not sent to isa");
    a_forward_needs_all: assert property (isa_forward |-> $past(isa_only)
        || (($past(match) & $past(range_enable) & $past(forward_enable)) != 14'h0000))
        else $error("isa forward without matched enabled range");
    a_ext_ide_quiet: assert property (pci_cyc_valid && pci_cyc_ext_ide
        && dack_ev == 14'h0000 && gpi_rise == 14'h0000 && !irq_rise
        |=> !global_reload && !fast_burst_reload && !slow_burst_reload
        && idle_reload == 14'h0000 && (trap_status & ~$past(trap_status)) == 14'h0000)
        else $error("external ide cycle produced an event");
    a_irq_global_reload: assert property (irq_activity && !st.irq_prev
        && irq_global_reload_enable |=> global_reload)
        else $error("irq activity did not reload global standby");
    a_ide_trap_smi: assert property (acc[0] && trap_enable[0] && internal_ide_enable
        |=> trap_status[0] && !system_mgmt_interrupt_n)
        else $error("ide trap did not set status and smi");
    a_idle_status_set: assert property (expire_v != 14'h0000
        |=> (idle_status & $past(expire_v)) == $past(expire_v))
        else $error("idle expiry did not set status");
    // smi is registered, so it follows the expiry smi enable one cycle late
    a_idle_smi_gate: assert property ((idle_status & $past(idle_smi_enable)) == 14'h0000
        && trap_status == 14'h0000 |-> system_mgmt_interrupt_n)
        else $error("smi asserted with no enabled status");
    a_dev0_no_fast: assert property (act == 14'h0001 |=> !fast_burst_reload)
        else $error("monitor 0 caused a fast burst reload");
    a_gpi_single_pulse: assert property (gpi_rise != 14'h0000
        |=> (gpi_rise & $past(gpi_rise)) == 14'h0000)
        else $error("gpi event pulsed twice");
    a_no_timer_1213: assert property (idle_reload[13:12] == 2'b00
        && idle_status[13:12] == 2'b00)
        else $error("monitor 12 or 13 touched an idle timer");
    a_shadow_write: assert property (io_cyc && pci_cyc_write && ioa == PAM_PRI_DRVHD
        |=> drive_select_shadow[0] == $past(pci_wdata[PAM_DRV_BIT]))
        else $error("primary drive select shadow not updated");

    c_global_reload: cover property (global_reload);
    c_ide_trap: cover property (trap_status[0] && !system_mgmt_interrupt_n);
    c_idle_expiry: cover property (expire_v != 14'h0000);
    c_isa_forward: cover property (isa_forward && !isa_only);
endmodule : pam_activity_monitor

/* File: rtl/pam_pkg.sv */
// pam_pkg: constants shared by the peripheral activity monitor files.
// assumes 16-bit i/o decode on the pci side; memory ranges use full 32 bits.
package pam_pkg;

    // ----------------------------------------
    // sizes
    // ----------------------------------------
    localparam int PAM_NUM_MON = 14;
    localparam int PAM_NUM_TMR = 12;
    localparam int PAM_TW = 8;
    localparam int PAM_DRV_BIT = 4;
    localparam int PAM_DACK_FDD = 2;

    // ----------------------------------------
    // fixed i/o decode
    // ----------------------------------------
    localparam logic [15:0] PAM_PRI_LO = 16'h01f0;
    localparam logic [15:0] PAM_PRI_HI = 16'h01f7;
    localparam logic [15:0] PAM_PRI_ALT = 16'h03f6;
    localparam logic [15:0] PAM_PRI_DRVHD = 16'h01f6;
    localparam logic [15:0] PAM_SEC_LO = 16'h0170;
    localparam logic [15:0] PAM_SEC_HI = 16'h0177;
    localparam logic [15:0] PAM_SEC_ALT = 16'h0376;
    localparam logic [15:0] PAM_SEC_DRVHD = 16'h0176;
    localparam logic [15:0] PAM_KBC_DATA = 16'h0060;
    localparam logic [15:0] PAM_KBC_CMD = 16'h0064;
    localparam logic [15:0] PAM_RTC_LO = 16'h0070;
    localparam logic [15:0] PAM_RTC_HI = 16'h0071;

    // ----------------------------------------
    // per-monitor capability masks, bit n is monitor n
    // ----------------------------------------
    localparam logic [13:0] PAM_FAST_OK = 14'h3ffe;
    localparam logic [13:0] PAM_SLOW_OK = 14'h002f;
    localparam logic [13:0] PAM_HAS_TIMER = 14'h0fff;
    localparam logic [13:0] PAM_IDE_MON = 14'h000f;
    localparam logic [13:0] PAM_HAS_GPI = 14'h3ffe;

endpackage : pam_pkg

/* File: rtl/pam_timer_if.sv */
// pam_timer_if: control and expiry of one idle timer.
// assumes a single clock shared by both ends.
`timescale 1ns/10ps
interface pam_timer_if;
    logic enable;
    logic reload;
    logic tick;
    logic freeze;
    logic [7:0] load_value;
    logic expire;

    modport ctrl (output enable, output reload, output tick, output freeze,
        output load_value, input expire);
    modport timer (input enable, input reload, input tick, input freeze,
        input load_value, output expire);
endinterface : pam_timer_if

/* File: rtl/pam_sync_edge.sv */
// pam_sync_edge: two-flop synchroniser for pin inputs plus one history stage.
// assumes inputs are asynchronous to clk; callers read only now and was.
`timescale 1ns/10ps
module pam_sync_edge #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [W-1:0] d,
    output logic [W-1:0] now,
    output logic [W-1:0] was
);
    typedef struct packed {
        logic [W-1:0] q1;
        logic [W-1:0] q2;
        logic [W-1:0] q3;
    } pam_sync_t;

    pam_sync_t st;
    pam_sync_t next_st;

    // q1 feeds only q2; q3 keeps the previous synchronised level for edges
    always_comb begin
        next_st.q1 = d;
        next_st.q2 = st.q1;
        next_st.q3 = st.q2;
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign now = st.q2;
    assign was = st.q3;
endmodule : pam_sync_edge

/* File: rtl/pam_idle_timer.sv */
// pam_idle_timer: one down-counting device idle timer.
// assumes tick is a one-cycle pulse per resolution step from the same clock.
`timescale 1ns/10ps
module pam_idle_timer
    import pam_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    pam_timer_if.timer t
);
    typedef struct packed {
        logic prev_en;
        logic running;
        logic [PAM_TW-1:0] count;
        logic expire;
    } pam_tmr_t;

    pam_tmr_t st;
    pam_tmr_t next_st;

    always_comb begin
        next_st = st;
        next_st.prev_en = t.enable;
        next_st.expire = 1'b0;
        if (!t.enable) begin
            next_st.running = 1'b0;
            next_st.count = t.load_value;
        end else if (t.reload || !st.prev_en) begin
            next_st.running = 1'b1;
            next_st.count = t.load_value;
        end else if (st.running && t.tick && !t.freeze) begin
            if (st.count <= 8'h01) begin
                next_st.count = 8'h00;
                next_st.running = 1'b0;
                next_st.expire = 1'b1;
            end else begin
                next_st.count = st.count - 8'h01;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign t.expire = st.expire;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    a_freeze_holds_count: assert property (@(posedge clk) disable iff (!rst_b)
        t.freeze && t.enable && st.prev_en && !t.reload |=> st.count == $past(st.count))
        else $error("idle timer moved while frozen");
    a_count_out_expires: assert property (@(posedge clk) disable iff (!rst_b)
        t.enable && st.prev_en && !t.reload && st.running && t.tick && !t.freeze
        && st.count <= 8'h01 |=> t.expire ##1 !t.expire)
        else $error("idle timer ran out without a single expiry pulse");
endmodule : pam_idle_timer

/* File: test/pam_pci_master.sv */
// pam_pci_master: pci master model issuing observed cycles to the monitor.
// assumes the monitor takes a cycle at the rising edge where valid is high.
`timescale 1ns/10ps
module pam_pci_master (
    input wire logic clk,
    output logic pci_cyc_valid,
    output logic pci_cyc_io,
    output logic pci_cyc_mem,
    output logic pci_cyc_write,
    output logic [31:0] pci_addr,
    output logic [7:0] pci_wdata,
    output logic pci_cyc_ext_ide
);
    initial begin
        {pci_cyc_valid, pci_cyc_io, pci_cyc_mem, pci_cyc_write, pci_cyc_ext_ide} = '0;
        {pci_addr, pci_wdata} = '1;
    end
    // qualifiers turn to their inverse once taken, so a stale value never decodes
    task automatic cycle(input logic io, input logic wr, input logic ext,
        input logic [31:0] ad, input logic [7:0] d);
        @(posedge clk);
        #1;
        {pci_cyc_io, pci_cyc_mem, pci_cyc_write, pci_cyc_ext_ide} = {io, ~io, wr, ext};
        {pci_addr, pci_wdata} = {ad, d};
        pci_cyc_valid = 1'b1;
        @(posedge clk);
        #1;
        pci_cyc_valid = 1'b0;
        {pci_cyc_io, pci_cyc_mem, pci_cyc_write, pci_cyc_ext_ide} = {~io, io, ~wr, ~ext};
        {pci_addr, pci_wdata} = ~{ad, d};
    endtask : cycle
endmodule : pam_pci_master

/* File: test/pam_activity_monitor_test.sv */
// pam_activity_monitor_test: self-checking bench for the activity monitor decode.
// assumes pam_pci_master supplies pci cycles; pins and controls are driven here.
`timescale 1ns/10ps
module pam_activity_monitor_test;
    import pam_pkg::*;
    // ----------------------------------------
    // signals and helpers
    // ----------------------------------------
    logic clk, rst_b, pci_cyc_valid, pci_cyc_io, pci_cyc_mem, pci_cyc_write, pci_cyc_ext_ide;
    logic primary_ide_dma_ack_n, secondary_ide_dma_ack_n, irq_activity, irq_global_reload_enable;
    logic internal_ide_enable, lpt_dack_enable, software_reload_disable, idle_timer_freeze;
    logic idle_tick, global_reload, fast_burst_reload, slow_burst_reload, isa_forward;
    logic system_mgmt_interrupt_n, hit;
    logic [31:0] pci_addr, a;
    logic [7:0] pci_wdata, isa_dma_ack_n, audio_dack_enable, idle_count_group_c;
    logic [7:0] idle_count_group_d, bus_master_idle_count;
    logic [1:0] bus_master_ide_active, lpt_dma_channel, drive_select_shadow;
    logic [3:0] idle_count_group_a, software_timer_count;
    logic [4:0] idle_count_group_b;
    logic [13:4] range_is_mem;
    logic [13:4][31:0] range_base, range_mask;
    logic [13:0] general_purpose_input, range_enable, forward_enable, idle_reload_en;
    logic [13:0] global_reload_en, burst_reload_en, burst_fast_sel, trap_enable, idle_smi_enable;
    logic [13:0] gpi_enable, gpi_polarity, idle_status_clear, trap_status_clear;
    logic [13:0] idle_reload, idle_status, trap_status;
    logic [15:0] lfsr;
    logic [31:0] fixed_isa [4] = '{32'h0000_0060, 32'h0000_0064, 32'h0000_0070, 32'h0000_0071};
    int miscompares = 0, checks = 0, n_gr = 0, n_fb = 0, n_sb = 0, n_fwd = 0, n_ir0 = 0;
    int n_ir12 = 0, b_gr, b_fb, b_sb, b_fwd;
    int q[$];

    pam_activity_monitor dut_u (.*);
    pam_pci_master pci_u (.clk(clk), .pci_cyc_valid(pci_cyc_valid), .pci_cyc_io(pci_cyc_io),
        .pci_cyc_mem(pci_cyc_mem), .pci_cyc_write(pci_cyc_write), .pci_addr(pci_addr),
        .pci_wdata(pci_wdata), .pci_cyc_ext_ide(pci_cyc_ext_ide));

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // pulse counters: a pulse wider than one cycle counts more than once and shows up
    always @(posedge clk) begin
        n_gr += (global_reload === 1'b1);
        n_fb += (fast_burst_reload === 1'b1);
        n_sb += (slow_burst_reload === 1'b1);
        n_fwd += (isa_forward === 1'b1);
        n_ir0 += (idle_reload[0] === 1'b1);
        n_ir12 += (idle_reload[12] === 1'b1);
    end
    initial begin
        #100000;
        miscompares++;
        conclude();
    end

    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr_next
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic conclude;
        $display("checks=%0d miscompares=%0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : conclude
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : step
    task automatic mark;
        b_gr = n_gr;
        b_fb = n_fb;
        b_sb = n_sb;
        b_fwd = n_fwd;
    endtask : mark
    task automatic pulses(input int gr, input int fb, input int sb, input int fwd);
        step(6);
        check(n_gr - b_gr, gr);
        check(n_fb - b_fb, fb);
        check(n_sb - b_sb, sb);
        check(n_fwd - b_fwd, fwd);
        mark();
    endtask : pulses
    task automatic clear_all;
        {trap_status_clear, idle_status_clear} = '1;
        step(1);
        {trap_status_clear, idle_status_clear} = '0;
        step(2);
        mark();
    endtask : clear_all
    task automatic tick(input int n);
        repeat (n) begin
            idle_tick = 1'b1;
            step(1);
            idle_tick = 1'b0;
            step(1);
        end
    endtask : tick
    // ----------------------------------------
    // sequence
    // ----------------------------------------
    initial begin
        {rst_b, irq_activity, irq_global_reload_enable, internal_ide_enable, idle_timer_freeze,
            idle_tick, bus_master_ide_active, range_enable, forward_enable, idle_reload_en,
            global_reload_en, burst_reload_en, burst_fast_sel, trap_enable, idle_smi_enable,
            gpi_enable, gpi_polarity, idle_status_clear, trap_status_clear,
            general_purpose_input, range_base, range_mask} = '0;
        {primary_ide_dma_ack_n, secondary_ide_dma_ack_n, isa_dma_ack_n} = '1;
        lfsr = 16'h0013;
        {audio_dack_enable, lpt_dack_enable, lpt_dma_channel, software_reload_disable} = lfsr[11:0];
        {idle_count_group_b, idle_count_group_c, idle_count_group_d, bus_master_idle_count,
            software_timer_count} = {lfsr, lfsr, lfsr[0]};
        range_is_mem = {lfsr[8:0], 1'b0};
        idle_count_group_a = 4'h2;
        step(10);
        rst_b = 1'b1;
        step(2);
        check(system_mgmt_interrupt_n, 1'b1);
        check({idle_status, trap_status}, 32'h0000_0000);
        {range_enable[1:0], global_reload_en[1:0], burst_reload_en[1:0]} = 6'h3f;
        {burst_fast_sel[1:0], trap_enable[1:0], internal_ide_enable, idle_reload_en[0]} = 6'h2f;
        step(2);
        mark();
        pci_u.cycle(1'b1, 1'b0, 1'b0, 32'h0000_01f2, 8'h00);
        check(trap_status, 14'h0001);
        check(system_mgmt_interrupt_n, 1'b0);
        pulses(1, 0, 1, 0);
        check(n_ir0, 1);
        clear_all();
        check(system_mgmt_interrupt_n, 1'b1);
        pci_u.cycle(1'b1, 1'b0, 1'b1, 32'h0000_01f2, 8'h00);
        pulses(0, 0, 0, 0);
        check(trap_status, 14'h0000);
        pci_u.cycle(1'b1, 1'b1, 1'b0, 32'h0000_01f6, 8'h10);
        step(1);
        check(drive_select_shadow, 2'b01);
        clear_all();
        pci_u.cycle(1'b1, 1'b0, 1'b0, 32'h0000_03f6, 8'h00);
        pulses(1, 1, 0, 0);
        check(trap_status, 14'h0002);
        pci_u.cycle(1'b1, 1'b1, 1'b0, 32'h0000_01f6, 8'h00);
        clear_all();
        internal_ide_enable = 1'b0;
        pci_u.cycle(1'b1, 1'b0, 1'b0, 32'h0000_01f2, 8'h00);
        pulses(1, 0, 1, 0);
        check(trap_status, 14'h0000);
        idle_reload_en[0] = 1'b0;
        step(2);
        {idle_reload_en[0], idle_timer_freeze} = 2'b11;
        step(2);
        tick(6);
        check(idle_status, 14'h0000);
        idle_timer_freeze = 1'b0;
        tick(1);
        step(4);
        check(idle_status, 14'h0000);
        tick(1);
        step(4);
        check(idle_status, 14'h0001);
        check(system_mgmt_interrupt_n, 1'b1);
        idle_smi_enable[0] = 1'b1;
        step(2);
        check(system_mgmt_interrupt_n, 1'b0);
        {idle_reload_en[0], idle_smi_enable[0]} = 2'b00;
        clear_all();
        // a held acknowledge must give one event only
        bus_master_ide_active = 2'b01;
        primary_ide_dma_ack_n = 1'b0;
        step(8);
        primary_ide_dma_ack_n = 1'b1;
        pulses(1, 0, 1, 0);
        check(trap_status, 14'h0000);
        {gpi_enable[12], gpi_polarity[12], global_reload_en[12], idle_reload_en[12]} = 4'hf;
        {burst_reload_en[12], burst_fast_sel[12]} = 2'b11;
        general_purpose_input[12] = 1'b1;
        step(8);
        general_purpose_input[12] = 1'b0;
        pulses(1, 1, 0, 0);
        check(n_ir12, 0);
        {irq_global_reload_enable, irq_activity} = 2'b11;
        step(4);
        irq_activity = 1'b0;
        pulses(1, 0, 0, 0);
        {irq_global_reload_enable, irq_activity} = 2'b01;
        step(4);
        irq_activity = 1'b0;
        pulses(0, 0, 0, 0);
        range_base[4] = 32'h0000_0220;
        range_mask[4] = 32'hffff_fff0;
        global_reload_en[4] = 1'b1;
        for (int i = 0; i < 16; i++) begin
            lfsr = lfsr_next(lfsr);
            {range_enable[4], forward_enable[4]} = lfsr[9:8];
            a = 32'h0000_0200 + {26'h0, lfsr[5:0]};
            hit = ((a & range_mask[4]) == (range_base[4] & range_mask[4]));
            q.push_back(int'(hit && lfsr[9] && lfsr[8]));
            q.push_back(int'(hit && lfsr[9]));
            pci_u.cycle(1'b1, lfsr[10], 1'b0, a, lfsr[7:0]);
            pulses(q[1], 0, 0, q[0]);
            q = {};
        end
        {range_enable[4], forward_enable[4]} = 2'b11;
        pci_u.cycle(1'b1, 1'b0, 1'b0, 32'h0000_0224, 8'h00);
        pulses(1, 0, 0, 1);
        isa_dma_ack_n[0] = 1'b0;
        step(4);
        isa_dma_ack_n[0] = 1'b1;
        pulses(1, 0, 0, 0);
        pci_u.cycle(1'b0, 1'b0, 1'b0, 32'h0000_0224, 8'h00);
        pulses(0, 0, 0, 0);
        forward_enable = '0;
        foreach (fixed_isa[i]) begin
            pci_u.cycle(1'b1, 1'b0, 1'b0, fixed_isa[i], 8'h00);
            pulses(0, 0, 0, 1);
        end
        conclude();
    end
endmodule : pam_activity_monitor_test
